// File: rtl/tsp_pkg.sv
// How it works
// R1: capture mosi only while select is low
// R2: miso released whenever select is high
// R3: sample mosi on serial clock falling edge
// R4: shift miso out on serial clock falling edge
// R5: host holds select low through transfers
// R6: host alone makes the serial clock
// R7: 16-bit registers picked by command word
// R8: written registers steer converter, dac, keypad
// R9: results readable any time, never refused
// R10: result_ready_n low once conversion completes
// R11: keypad_irq_n asserted on key press
// R12: touch_irq asserted while touch detected
// R13: keypad_irq_n active low, high otherwise
package tsp_pkg;
  // ****************************************
  // word layout
  // ****************************************
  localparam int unsigned TSP_WORD_W = 16;
  localparam int unsigned TSP_CNT_W = 5;
  localparam logic [4:0] TSP_CMD_LAST = 5'h0F;
  localparam logic [4:0] TSP_DATA_LAST = 5'h1F;
  localparam int unsigned TSP_CMD_RD_BIT = 15;
  localparam int unsigned TSP_ADDR_W = 3;
  // ****************************************
  // register indices
  // ****************************************
  localparam logic [2:0] TSP_ADC_CTRL = 3'h0;
  localparam logic [2:0] TSP_DAC_CTRL = 3'h1;
  localparam logic [2:0] TSP_KEY_CTRL = 3'h2;
  localparam logic [2:0] TSP_STATUS = 3'h3;
  localparam logic [2:0] TSP_RESULT = 3'h4;
  localparam logic [2:0] TSP_KEY_CODE = 3'h5;
  // ****************************************
  // status bits and reset values
  // ****************************************
  localparam int unsigned TSP_ST_RESULT = 0;
  localparam int unsigned TSP_ST_KEY = 1;
  localparam int unsigned TSP_ST_TOUCH = 2;
  localparam logic [15:0] TSP_CTRL_RST = 16'h0000;
  localparam int unsigned TSP_SYNC_W = 3;
  // idle pin levels {sclk, ss_n, mosi} held by the synchroniser in reset
  localparam logic [2:0] TSP_PIN_IDLE = 3'h6;
endpackage : tsp_pkg

// File: rtl/tsp_sync.sv
`timescale 1ns/1ps
`default_nettype none
module tsp_sync #(
  parameter int unsigned W = 1
) (
  input wire logic sys_clk_in, // block clock
  input wire logic rst_in, // sync reset, active high
  input wire logic [W-1:0] async_in, // foreign-domain levels
  input wire logic [W-1:0] rst_val_in, // idle level after reset
  output logic [W-1:0] sync_out // two-stage synchronised
);
  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_sync;

  // first stage only feeds the second
  always_comb begin
    next_meta = rst_in ? rst_val_in : async_in;
    next_sync = rst_in ? rst_val_in : meta;
  end

  always_ff @(posedge sys_clk_in) begin
    meta <= next_meta;
    sync_out <= next_sync;
  end
endmodule : tsp_sync
`default_nettype wire

// File: rtl/tsp_host_port.sv
`timescale 1ns/1ps
`default_nettype none
module tsp_host_port
  import tsp_pkg::*;
(
  input wire logic sys_clk_in, // 25 MHz block clock
  input wire logic rst_in, // sync reset, active high
  input wire logic sclk_in, // serial clock from host
  input wire logic ss_n_in, // slave select, active low
  input wire logic mosi_in, // serial data in
  output logic miso_out, // serial data out
  output logic miso_oe_out, // high while miso driven
  input wire logic conv_done_in, // conversion finished pulse
  input wire logic [15:0] adc_result_in, // conversion result
  input wire logic key_press_in, // key pressed pulse
  input wire logic [15:0] key_code_in, // pressed key code
  input wire logic touch_detect_in, // touch present level
  output logic [15:0] adc_ctrl_out, // converter control
  output logic [15:0] dac_ctrl_out, // current dac control
  output logic [15:0] key_ctrl_out, // keypad scanner control
  output logic result_ready_n, // result waiting, active low
  output logic keypad_irq_n, // key event, active low
  output logic touch_irq_out // touch present
);
  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [2:0] pins_s;
  logic sclk_s, ss_s, mosi_s;
  tsp_sync #(.W(TSP_SYNC_W)) u_sync (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .async_in({sclk_in, ss_n_in, mosi_in}),
    .rst_val_in(TSP_PIN_IDLE),
    .sync_out(pins_s)
  );
  assign {sclk_s, ss_s, mosi_s} = pins_s;

  // ****************************************
  // serial state
  // ****************************************
  logic sclk_q, next_sclk_q;
  logic sclk_fall;
  logic [4:0] bit_cnt, next_bit_cnt;
  logic [14:0] shift_in, next_shift_in;
  logic [15:0] shift_out, next_shift_out;
  logic cmd_rd, next_cmd_rd;
  logic [2:0] addr, next_addr;
  logic [15:0] in_word;
  logic [15:0] rd_word;
  logic [2:0] cmd_addr;
  logic cmd_done, rd_start, wr_done;
  logic next_miso, next_oe;

  // edge found on synchronised copy; the raw pin is never looked at
  assign sclk_fall = sclk_q & ~sclk_s; // see R3
  assign in_word = {shift_in, mosi_s};
  assign cmd_addr = in_word[TSP_ADDR_W-1:0];
  assign cmd_done = ~ss_s & sclk_fall & (bit_cnt == TSP_CMD_LAST); // see R7
  assign rd_start = cmd_done & in_word[TSP_CMD_RD_BIT];
  assign wr_done = ~ss_s & sclk_fall & (bit_cnt == TSP_DATA_LAST) & ~cmd_rd;

  // ****************************************
  // register state
  // ****************************************
  logic [15:0] adc_ctrl, dac_ctrl, key_ctrl, result, key_code;
  logic [15:0] next_adc_ctrl, next_dac_ctrl, next_key_ctrl, next_result, next_key_code;
  logic res_flag, key_flag, touch;
  logic next_res_flag, next_key_flag, next_touch;

  // read mux: every index answers at once, no wait states
  always_comb begin
    unique case (cmd_addr)
      TSP_ADC_CTRL: rd_word = adc_ctrl;
      TSP_DAC_CTRL: rd_word = dac_ctrl;
      TSP_KEY_CTRL: rd_word = key_ctrl;
      TSP_STATUS: rd_word = {13'h0000, touch, key_flag, res_flag};
      TSP_RESULT: rd_word = result; // see R9
      TSP_KEY_CODE: rd_word = key_code;
      default: rd_word = 16'h0000;
    endcase
  end

  // serial next state
  always_comb begin
    next_sclk_q = sclk_s;
    next_bit_cnt = bit_cnt;
    next_shift_in = shift_in;
    next_shift_out = shift_out;
    next_cmd_rd = cmd_rd;
    next_addr = addr;
    if (ss_s) begin
      // deselected: bits on mosi are dropped and the frame restarts
      next_bit_cnt = 5'h00; // see R1
      next_shift_out = 16'h0000;
    end else if (sclk_fall) begin
      next_bit_cnt = bit_cnt + 5'h01; // see R3
      next_shift_in = in_word[14:0];
      next_shift_out = {shift_out[14:0], 1'b0}; // see R4
      if (cmd_done) begin
        next_cmd_rd = in_word[TSP_CMD_RD_BIT];
        next_addr = cmd_addr;
        next_shift_out = rd_start ? rd_word : 16'h0000; // see R4
      end
    end
  end

  // miso: driven only while selected, updated on falling edges
  always_comb begin
    next_oe = ~ss_s; // see R2
    next_miso = next_shift_out[15];
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      sclk_q <= 1'b1; // matches the idle-high pin, so no false edge after reset
      bit_cnt <= 5'h00;
      shift_in <= 15'h0000;
      shift_out <= 16'h0000;
      cmd_rd <= 1'b0;
      addr <= 3'h0;
      miso_out <= 1'b0;
      miso_oe_out <= 1'b0;
    end else begin
      sclk_q <= next_sclk_q;
      bit_cnt <= next_bit_cnt;
      shift_in <= next_shift_in;
      shift_out <= next_shift_out;
      cmd_rd <= next_cmd_rd;
      addr <= next_addr;
      miso_out <= next_miso;
      miso_oe_out <= next_oe;
    end
  end

  // ****************************************
  // register file and event flags
  // ****************************************
  always_comb begin
    next_adc_ctrl = adc_ctrl;
    next_dac_ctrl = dac_ctrl;
    next_key_ctrl = key_ctrl;
    next_result = conv_done_in ? adc_result_in : result;
    next_key_code = key_press_in ? key_code_in : key_code;
    next_touch = touch_detect_in; // see R12
    if (wr_done) begin
      unique case (addr)
        TSP_ADC_CTRL: next_adc_ctrl = in_word; // see R8
        TSP_DAC_CTRL: next_dac_ctrl = in_word; // see R8
        TSP_KEY_CTRL: next_key_ctrl = in_word; // see R8
        default: next_adc_ctrl = adc_ctrl;
      endcase
    end
    // reading the word clears its flag; a new event in that cycle wins
    next_res_flag = res_flag;
    if (rd_start && cmd_addr == TSP_RESULT) next_res_flag = 1'b0;
    if (conv_done_in) next_res_flag = 1'b1; // see R10
    next_key_flag = key_flag;
    if (rd_start && cmd_addr == TSP_KEY_CODE) next_key_flag = 1'b0;
    if (key_press_in) next_key_flag = 1'b1; // see R11
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      adc_ctrl <= TSP_CTRL_RST;
      dac_ctrl <= TSP_CTRL_RST;
      key_ctrl <= TSP_CTRL_RST;
      result <= 16'h0000;
      key_code <= 16'h0000;
      res_flag <= 1'b0;
      key_flag <= 1'b0;
      touch <= 1'b0;
    end else begin
      adc_ctrl <= next_adc_ctrl;
      dac_ctrl <= next_dac_ctrl;
      key_ctrl <= next_key_ctrl;
      result <= next_result;
      key_code <= next_key_code;
      res_flag <= next_res_flag;
      key_flag <= next_key_flag;
      touch <= next_touch;
    end
  end

  // host-facing outputs straight from flops
  assign adc_ctrl_out = adc_ctrl;
  assign dac_ctrl_out = dac_ctrl;
  assign key_ctrl_out = key_ctrl;
  assign result_ready_n = ~res_flag; // see R10
  assign keypad_irq_n = ~key_flag; // see R13
  assign touch_irq_out = touch; // see R12

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  a_miso_release: assert property (ss_s |=> !miso_oe_out) // see R2
    else $error("miso driven while deselected");
  a_capture_gated: assert property (ss_s |=> bit_cnt == 5'h00) // see R1
    else $error("bit counted while deselected");
  a_sample_fall: assert property ((!ss_s && !$past(ss_s) && bit_cnt != $past(bit_cnt)) |-> $past(sclk_fall)) // see R3
    else $error("bit taken without falling edge");
  a_miso_shift: assert property ((miso_out != $past(miso_out)) |-> ($past(sclk_fall) || $past(ss_s))) // see R4
    else $error("miso moved off a falling edge");
  a_read_word: assert property (rd_start |=> miso_out == $past(rd_word[15])) // see R9
    else $error("read word not presented");
  a_write_ctrl: assert property ((wr_done && addr == TSP_ADC_CTRL) |=> adc_ctrl_out == $past(in_word)) // see R8
    else $error("control write lost");
  a_result_ready: assert property (conv_done_in |=> !result_ready_n) // see R10
    else $error("result ready not flagged");
  a_keypad_irq: assert property (key_press_in |=> !keypad_irq_n) // see R11
    else $error("key event not flagged");
  a_touch_irq: assert property (touch_detect_in |=> touch_irq_out ##0 touch_irq_out == $past(touch_detect_in)) // see R12
    else $error("touch not reported");
endmodule : tsp_host_port
`default_nettype wire

// File: bench/tsp_spi_host.sv
`timescale 1ns/1ps
`default_nettype none
module tsp_spi_host (
  input wire logic clk_in, // block clock, paces the link
  input wire logic miso_in, // wire level of serial out
  output logic sclk_out, // serial clock, idle high
  output logic ss_n_out, // select, active low
  output logic mosi_out, // serial data to device
  output logic rd_stb_out, // one cycle after a read frame
  output logic [15:0] rd_word_out // word shifted back
);
  // ****************************************
  // frame engine
  // ****************************************
  // idle levels; the clock stands still between frames
  initial begin
    sclk_out = 1'b1;
    ss_n_out = 1'b1;
    mosi_out = 1'b0;
    rd_stb_out = 1'b0;
    rd_word_out = 16'h0000;
  end
  // 8 clocks per bit is 320 ns; a stray frame keeps select high
  task automatic xfer(input logic stray, input logic [15:0] cmd, input logic [15:0] dat);
    logic [31:0] sh;
    logic [15:0] rd;
    sh = {cmd, dat};
    rd = 16'h0000;
    @(posedge clk_in);
    ss_n_out <= stray;
    repeat (8) @(posedge clk_in);
    for (int i = 0; i < 32; i++) begin
      mosi_out <= sh[31 - i];
      repeat (4) @(posedge clk_in);
      // sampled late in the high phase, well clear of the shift lag
      if (i >= 16) rd[31 - i] = miso_in;
      sclk_out <= 1'b0;
      repeat (4) @(posedge clk_in);
      sclk_out <= 1'b1;
    end
    // the last bit was taken inside the loop; miso has shifted past it by now
    repeat (4) @(posedge clk_in);
    ss_n_out <= 1'b1;
    mosi_out <= ~mosi_out;
    rd_word_out <= rd;
    rd_stb_out <= cmd[15] & ~stray;
    @(posedge clk_in);
    rd_stb_out <= 1'b0;
    repeat (8) @(posedge clk_in);
  endtask : xfer
endmodule : tsp_spi_host
`default_nettype wire

// File: bench/tsp_host_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tsp_host_port_tb import tsp_pkg::*;;
  logic sys_clk_in = 1'b0, rst_in = 1'b1, sclk, ss_n, mosi, miso_out, miso_oe_out;
  logic conv_done = 1'b0, key_press = 1'b0, touch = 1'b0, rd_stb;
  logic [15:0] adc_result = 16'h0000, key_code = 16'h0000, rd_word;
  logic [15:0] adc_ctrl, dac_ctrl, key_ctrl;
  logic result_ready_n, keypad_irq_n, touch_irq;
  wire logic miso_w;
  logic [15:0] q [$];
  int n_fail = 0, samples_checked = 0, cycles = 0;
  // ****************************************
  // harness
  // ****************************************
  // released line shows the inverse, so a read while unselected cannot match
  assign miso_w = miso_oe_out ? miso_out : ~miso_out;
  always #20 sys_clk_in = ~sys_clk_in;
  tsp_host_port tsp_host_port_inst (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .sclk_in(sclk),
    .ss_n_in(ss_n), .mosi_in(mosi), .miso_out(miso_out), .miso_oe_out(miso_oe_out),
    .conv_done_in(conv_done), .adc_result_in(adc_result), .key_press_in(key_press),
    .key_code_in(key_code), .touch_detect_in(touch), .adc_ctrl_out(adc_ctrl),
    .dac_ctrl_out(dac_ctrl), .key_ctrl_out(key_ctrl), .result_ready_n(result_ready_n),
    .keypad_irq_n(keypad_irq_n), .touch_irq_out(touch_irq));
  tsp_spi_host tsp_spi_host_inst (.clk_in(sys_clk_in), .miso_in(miso_w), .sclk_out(sclk),
    .ss_n_out(ss_n), .mosi_out(mosi), .rd_stb_out(rd_stb), .rd_word_out(rd_word));
  // ****************************************
  // checking
  // ****************************************
  task automatic chk(input logic [15:0] exp, input logic [15:0] act);
    samples_checked++;
    if (exp !== act) begin
      n_fail++;
      $display("wrong value at %0t: expected %h got %h", $time, exp, act);
    end
  endtask : chk
  task automatic finish_test();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test
  function automatic logic [15:0] flags();
    return {12'h000, miso_oe_out, touch_irq, keypad_irq_n, result_ready_n};
  endfunction : flags
  // read words are matched oldest first against the notes
  always @(posedge sys_clk_in) begin
    if (rd_stb === 1'b1) chk(q.pop_front(), rd_word);
  end
  // hang guard, a full run needs about 3100 cycles
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      finish_test();
    end
  end
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    logic [15:0] v [3];
    logic [15:0] r;
    void'($urandom(32'h553C7710));
    repeat (3) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    repeat (3) @(posedge sys_clk_in);
    #1 chk(16'h0003, flags());
    chk(TSP_CTRL_RST, adc_ctrl | dac_ctrl | key_ctrl);
    for (int i = 0; i < 3; i++) begin
      v[i] = 16'($urandom);
      tsp_spi_host_inst.xfer(1'b0, {13'h0000, 3'(i)}, v[i]);
    end
    #1 chk(v[0], adc_ctrl);
    chk(v[1], dac_ctrl);
    chk(v[2], key_ctrl);
    for (int i = 0; i < 3; i++) begin
      q.push_back(v[i]);
      tsp_spi_host_inst.xfer(1'b0, 16'h8000 | 16'(i), 16'($urandom));
    end
    tsp_spi_host_inst.xfer(1'b1, {13'h0000, TSP_ADC_CTRL}, ~v[0]);
    #1 chk(v[0], adc_ctrl);
    chk(16'h0003, flags());
    r = 16'($urandom);
    @(posedge sys_clk_in);
    conv_done <= 1'b1;
    adc_result <= r;
    key_press <= 1'b1;
    key_code <= ~r;
    @(posedge sys_clk_in);
    conv_done <= 1'b0;
    key_press <= 1'b0;
    adc_result <= 16'($urandom);
    key_code <= 16'($urandom);
    @(posedge sys_clk_in);
    #1 chk(16'h0000, flags());
    q.push_back(r);
    tsp_spi_host_inst.xfer(1'b0, 16'h8004, 16'h0000);
    #1 chk(16'h0001, flags());
    q.push_back(~r);
    tsp_spi_host_inst.xfer(1'b0, 16'h8005, 16'h0000);
    #1 chk(16'h0003, flags());
    @(posedge sys_clk_in);
    touch <= 1'b1;
    repeat (3) @(posedge sys_clk_in);
    #1 chk(16'h0007, flags());
    q.push_back(16'h0001 << TSP_ST_TOUCH);
    tsp_spi_host_inst.xfer(1'b0, 16'h8003, 16'h0000);
    touch <= 1'b0;
    q.push_back(16'h0000);
    tsp_spi_host_inst.xfer(1'b0, 16'h8007, 16'h0000);
    #1 chk(16'h0003, flags());
    chk(16'h0000, 16'(q.size()));
    finish_test();
  end
endmodule : tsp_host_port_tb
`default_nettype wire
